// ---- src/xtsd_pkg.sv ----
// package: opcodes, field positions, constants and carriers for the decode block
package xtsd_pkg;
   // opcode patterns
   localparam logic [6:0] OP_TEST_SKIP = 7'h33;      // 0110 011 in bits 15:9
   localparam logic [7:0] OP_LIT_XOR = 8'h0a;        // 0000 1010 in bits 15:8
   localparam logic [5:0] OP_REG_XOR = 6'h06;        // 0001 10 in bits 15:10
   localparam logic [7:0] OP_PTR_ADD = 8'he8;        // pointer add / stack add and return
   localparam logic [7:0] OP_PTR_SUB = 8'he9;        // pointer sub / stack sub and return
   localparam logic [7:0] OP_PUSH_LIT = 8'hea;       // push literal
   localparam logic [7:0] OP_MOVE_STACK = 8'heb;     // move from stack, first word
   localparam logic [3:0] OP_SECOND_WORD = 4'hf;     // second word prefix
   localparam logic [15:0] OP_CALL_ACC = 16'h0014;   // call via accumulator
   localparam logic [3:0] OP_TWO_WORD_A = 4'hc;      // other two-word opcodes (1100)
   localparam logic [7:0] OP_TWO_WORD_B = 8'hee;     // two-word load literal prefix
   localparam logic [6:0] OP_TWO_WORD_C = 7'h76;     // two-word call / goto family (1110 110x)
   // field positions
   localparam int DEST_BIT = 9;                      // destination bit
   localparam int BANK_BIT = 8;                      // bank bit
   localparam int SEL_MSB = 7;                       // pointer select msb
   localparam int MOVE_MODE_BIT = 7;                 // absolute/offset destination
   // constants
   localparam logic [7:0] INDEX_LIMIT = 8'h5f;       // highest indexed offset, 95
   localparam logic [1:0] SEL_STACK = 2'h3;          // select value that means return
   localparam logic [1:0] STACK_PTR_IDX = 2'h2;      // stack pointer register index
   localparam logic [3:0] ACCESS_BANK = 4'h0;        // bank of access addresses
   localparam logic [3:0] ACCESS_HIGH_BANK = 4'hf;   // upper access half
   localparam logic [7:0] ACC_RESET = 8'h00;         // accumulator after reset
   localparam logic [11:0] PTR_RESET = 12'h000;      // pointers after reset
   localparam logic EXT_DEFAULT = 1'b1;              // unprogrammed: extension on

   // data memory request from the block
   typedef struct packed {
      logic rd;          // read strobe
      logic wr;          // write strobe
      logic [11:0] addr; // full data address
      logic [7:0] wdata; // write data
   } xtsd_mem_t;

   // control-flow requests to the rest of the core
   typedef struct packed {
      logic flushNext;   // discard the fetched word, run a no-operation
      logic doReturn;    // load program counter from return stack top
      logic doCallAcc;   // call through the accumulator
      logic [7:0] moveSrcOff; // move-from-stack source offset
      logic [11:0] moveDest;  // move-from-stack destination field
      logic moveAbs;     // destination is absolute
      logic moveGo;      // move-from-stack decoded with its second word
   } xtsd_flow_t;
endpackage : xtsd_pkg

// ---- src/xtsd_core.sv ----
// decode and execute of skip, exclusive-or and extension instructions
`timescale 1ns/1ps
// What this block does
// - test register skip; zero discards next word
// - skip costs one or two extra cycles
// - bank bit picks access or selected bank
// - extension and bank0 low offsets indexed
// - literal exclusive-or into accumulator, flags
// - register exclusive-or with flags, one cycle
// - destination bit picks accumulator or register
// - extension only when config bit set
// - pointer add and subtract six-bit literal
// - select three adjusts stack, then returns
// - fixed word calls through the accumulator
// - two-word move from stack decoded
// - push literal, then decrement stack pointer

// how it runs
// one rising edge of ref_clk is one instruction cycle. A word is taken on an
// edge where instrValid is high and the block is not busy or is waiting for the second word of a move. All of its effects
// (memory request, flow request, accumulator, flags, pointers) are registered
// on that same edge and so show on the outputs one cycle later.
//
// memReq and flow are single-cycle pulses: the surrounding core must act on
// them in the cycle they appear, because the next edge clears them again.
//
// memRdata is expected to hold the byte at the address that the current word
// decodes to, in the same cycle. The surrounding core forms that address from
// the word in flight; this block forms the same address again for memReq.
//
// busy covers every cycle in which a fetched word must not be executed:
//  - the no-op cycle after a taken skip, plus one more when the discarded
//    word turns out to be the first half of a two-word instruction;
//  - the no-op cycle after a stack add/subtract with return;
//  - the no-op cycle after a call through the accumulator;
//  - the wait for the second word of a move from stack.
// words presented while busy in a no-op cycle are dropped.
//
// the extension enable is caught in a flop after reset and is read from that
// flop only, so a change takes effect one cycle late. Its reset value is the
// enabled state, which is what an unprogrammed part shows.
//
// limitations a user should know:
//  - a skip decides on memRdata of the take cycle; the read strobe that follows
//    is informational only;
//  - a move from stack whose second word lacks the all-ones prefix is dropped
//    without any flow request;
//  - pointer arithmetic wraps inside the pointer width.
module xtsd_core #(
   parameter int DATA_W = 8,   // data width
   parameter int ADDR_W = 12   // data address width
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic resetn,
   // instruction stream: one word per instruction cycle
   input wire logic [15:0] instrWord,
   input wire logic instrValid,
   // configuration
   input wire logic extConfig,
   // core state
   input wire logic [3:0] bankSelect,
   input wire logic [DATA_W-1:0] memRdata,
   // outputs
   output xtsd_pkg::xtsd_mem_t memReq,
   output xtsd_pkg::xtsd_flow_t flow,
   output logic [DATA_W-1:0] accOut,
   output logic negFlag,
   output logic zeroFlag,
   output logic [ADDR_W-1:0] ptrOut [3],
   output logic busy
);
   // instruction cycle phases
   typedef enum logic [1:0] {XT_EXEC, XT_NOP, XT_SECOND} xtsd_state_t;

   xtsd_state_t state_q, state_d;            // sequencing state
   logic [1:0] nopLeft_q, nopLeft_d;         // extra no-op cycles still due
   logic [DATA_W-1:0] acc_q, acc_d;          // accumulator
   logic neg_q, neg_d, zero_q, zero_d;       // status flags
   logic [ADDR_W-1:0] ptr_q [3];             // pointer registers
   logic [ADDR_W-1:0] ptr_d [3];
   logic [15:0] first_q, first_d;            // held first word of a move
   xtsd_pkg::xtsd_mem_t mem_q, mem_d;        // registered memory request
   xtsd_pkg::xtsd_flow_t flow_q, flow_d;     // registered flow request
   logic cfg_q;                              // extension enable, caught after reset
   logic flowWasSkip_q, flowWasSkip_d;       // previous edge took a skip

   // form full data address from bank bit and 8-bit field
   function automatic logic [11:0] fullAddr(input logic bankBit, input logic [7:0] f,
                                             input logic [3:0] bank_select_register, input logic ext,
                                             input logic [11:0] stackPtr);
      if (bankBit) begin
         fullAddr = {bank_select_register, f};
      end else if (ext && (f <= xtsd_pkg::INDEX_LIMIT)) begin
         fullAddr = 12'(stackPtr + {4'h0, f});
      end else if (f[7]) begin
         fullAddr = {xtsd_pkg::ACCESS_HIGH_BANK, f};
      end else begin
         fullAddr = {xtsd_pkg::ACCESS_BANK, f};
      end
   endfunction : fullAddr

   // true when the word is the first of a two-word instruction
   function automatic logic isTwoWord(input logic [15:0] w, input logic ext);
      isTwoWord = (w[15:12] == xtsd_pkg::OP_TWO_WORD_A)
         || (w[15:8] == xtsd_pkg::OP_TWO_WORD_B)
         || (w[15:9] == xtsd_pkg::OP_TWO_WORD_C)
         || (ext && (w[15:8] == xtsd_pkg::OP_MOVE_STACK));
   endfunction : isTwoWord

   // configuration bit is sampled on every edge once reset is released
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         cfg_q <= xtsd_pkg::EXT_DEFAULT;
      end else begin
         cfg_q <= extConfig;
      end
   end

   // next-state and datapath
   always_comb begin
      logic [7:0] res;
      logic [11:0] addr;
      logic [1:0] sel;
      logic [11:0] lit6;
      res = '0;
      addr = '0;
      sel = '0;
      lit6 = '0;
      state_d = state_q;
      nopLeft_d = nopLeft_q;
      acc_d = acc_q;
      neg_d = neg_q;
      zero_d = zero_q;
      ptr_d = ptr_q;
      first_d = first_q;
      mem_d = '0;
      flow_d = '0;
      addr = fullAddr(instrWord[xtsd_pkg::BANK_BIT], instrWord[7:0], bankSelect, cfg_q,
                      ptr_q[xtsd_pkg::STACK_PTR_IDX]);
      // pointer select sits just above the literal field
      sel = instrWord[xtsd_pkg::SEL_MSB:xtsd_pkg::SEL_MSB-1];
      // six-bit literal, zero extended to pointer width
      lit6 = {6'h00, instrWord[5:0]};
      case (state_q)
         // burn no-op cycles of a skip, a return or a call through the accumulator
         XT_NOP: begin
            if (flowWasSkip_q && isTwoWord(instrWord, cfg_q)) begin
               // discarded word is the first of two: one more no-op follows
               // so that its second word is not run as an instruction
               nopLeft_d = 2'd1;
            end else if (nopLeft_q <= 2'd1) begin
               // last no-op: next word is a fresh instruction
               state_d = XT_EXEC;
               nopLeft_d = 2'd0;
            end else begin
               nopLeft_d = nopLeft_q - 2'd1;
            end
         end
         // second word of a move from stack
         XT_SECOND: begin
            // wait here until the second word is offered
            if (instrValid) begin
               state_d = XT_EXEC;
               if (instrWord[15:12] == xtsd_pkg::OP_SECOND_WORD) begin
                  flow_d.moveGo = 1'b1;
                  flow_d.moveSrcOff = {1'b0, first_q[6:0]};
                  flow_d.moveAbs = ~first_q[xtsd_pkg::MOVE_MODE_BIT];
                  flow_d.moveDest = instrWord[11:0];
               end
            end
         end
         // first cycle of every instruction
         default: begin
            if (!instrValid) begin
               state_d = XT_EXEC;
            end else if (instrWord[15:9] == xtsd_pkg::OP_TEST_SKIP) begin
               // flags stay untouched
               mem_d.rd = 1'b1;
               mem_d.addr = addr;
               if (memRdata == '0) begin
                  flow_d.flushNext = 1'b1;
                  state_d = XT_NOP;
                  nopLeft_d = 2'd1;
               end
            end else if (instrWord[15:8] == xtsd_pkg::OP_LIT_XOR) begin
               res = acc_q ^ instrWord[7:0];
               acc_d = res;
               neg_d = res[7];
               zero_d = (res == 8'h00);
            end else if (instrWord[15:10] == xtsd_pkg::OP_REG_XOR) begin
               mem_d.rd = 1'b1;
               mem_d.addr = addr;
               res = acc_q ^ memRdata;
               neg_d = res[7];
               zero_d = (res == 8'h00);
               if (instrWord[xtsd_pkg::DEST_BIT]) begin
                  mem_d.wr = 1'b1;
                  mem_d.wdata = res;
               end else begin
                  acc_d = res;
               end
               // no skip: one cycle, nothing else happens
            end else if (cfg_q && ((instrWord[15:8] == xtsd_pkg::OP_PTR_ADD)
                                   || (instrWord[15:8] == xtsd_pkg::OP_PTR_SUB))) begin
               // select three always works on the stack pointer and returns
               if (sel == xtsd_pkg::SEL_STACK) begin
                  sel = xtsd_pkg::STACK_PTR_IDX;
                  flow_d.doReturn = 1'b1;
                  state_d = XT_NOP;
                  nopLeft_d = 2'd1;
               end
               if (instrWord[8]) begin
                  ptr_d[sel] = ptr_q[sel] - lit6;
               end else begin
                  ptr_d[sel] = ptr_q[sel] + lit6;
               end
               // bit 8 tells subtract from add
            end else if (cfg_q && (instrWord == xtsd_pkg::OP_CALL_ACC)) begin
               // target forming is left to the program counter logic
               flow_d.doCallAcc = 1'b1;
               state_d = XT_NOP;
               nopLeft_d = 2'd1;
            end else if (cfg_q && (instrWord[15:8] == xtsd_pkg::OP_PUSH_LIT)) begin
               // store goes to the old stack pointer value
               mem_d.wr = 1'b1;
               mem_d.addr = ptr_q[xtsd_pkg::STACK_PTR_IDX];
               mem_d.wdata = instrWord[7:0];
               ptr_d[xtsd_pkg::STACK_PTR_IDX] = ptr_q[xtsd_pkg::STACK_PTR_IDX] - 12'h001;
            end else if (cfg_q && (instrWord[15:8] == xtsd_pkg::OP_MOVE_STACK)) begin
               // keep the first word until its partner arrives
               first_d = instrWord;
               state_d = XT_SECOND;
            end
         end
      endcase
   end

   // remember a taken skip so the first no-op cycle can look at the
   // discarded word and stretch the skip over a two-word instruction
   always_comb begin
      flowWasSkip_d = flow_d.flushNext;
   end

   // register all state
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         state_q <= XT_EXEC;
         nopLeft_q <= 2'd0;
         acc_q <= xtsd_pkg::ACC_RESET;
         neg_q <= 1'b0;
         zero_q <= 1'b0;
         for (int i = 0; i < 3; i++) begin
            ptr_q[i] <= xtsd_pkg::PTR_RESET;
         end
         first_q <= 16'h0000;
         mem_q <= '0;
         flow_q <= '0;
         flowWasSkip_q <= 1'b0;
      end else begin
         state_q <= state_d;
         nopLeft_q <= nopLeft_d;
         acc_q <= acc_d;
         neg_q <= neg_d;
         zero_q <= zero_d;
         ptr_q <= ptr_d;
         first_q <= first_d;
         mem_q <= mem_d;
         flow_q <= flow_d;
         flowWasSkip_q <= flowWasSkip_d;
      end
   end

   // outputs from flip-flops
   // busy is decoded from the state register only, so it carries no
   // path from the instruction inputs
   assign memReq = mem_q;
   assign flow = flow_q;
   assign accOut = acc_q;
   assign negFlag = neg_q;
   assign zeroFlag = zero_q;
   assign ptrOut = ptr_q;
   assign busy = (state_q != XT_EXEC);
endmodule : xtsd_core

// ---- sim/xtsd_core_props.sv ----
// checker: port timing relations of the decode block
`timescale 1ns/1ps
module xtsd_core_props (
   // clock, reset and inputs
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic [15:0] instrWord,
   input wire logic instrValid,
   input wire logic extConfig,
   input wire logic [3:0] bankSelect,
   input wire logic [7:0] memRdata,
   // outputs
   input xtsd_pkg::xtsd_mem_t memReq,
   input xtsd_pkg::xtsd_flow_t flow,
   input wire logic [7:0] accOut,
   input wire logic negFlag,
   input wire logic zeroFlag,
   input wire logic [11:0] ptrOut [3],
   input wire logic busy
);
   logic extQ; // config seen one edge earlier
   always_ff @(posedge ref_clk) extQ <= extConfig;
   // decode helpers on a take edge
   wire logic take = instrValid && !busy;
   wire logic [7:0] hi = instrWord[15:8];
   wire logic litX = take && hi == xtsd_pkg::OP_LIT_XOR;
   wire logic regX = take && instrWord[15:10] == xtsd_pkg::OP_REG_XOR;
   wire logic skipT = take && instrWord[15:9] == xtsd_pkg::OP_TEST_SKIP;
   wire logic extT = take && extConfig && extQ;
   wire logic retT = extT && hi[7:1] == 7'h74 && instrWord[7:6] == xtsd_pkg::SEL_STACK;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!resetn);
   lit_xor_acc_a: assert property (litX |=>
      accOut == ($past(accOut) ^ $past(instrWord[7:0]))) else $error("literal xor wrong");
   xor_flag_a: assert property (litX |=>
      negFlag == accOut[7] && zeroFlag == (accOut == 8'h00)) else $error("xor flags wrong");
   skip_flush_a: assert property (skipT && memRdata == 8'h00 |=>
      flow.flushNext && busy) else $error("skip did not flush");
   skip_pass_a: assert property (skipT && memRdata != 8'h00 |=>
      !flow.flushNext && !busy && $stable(negFlag) && $stable(zeroFlag)) else $error("bad skip");
   reg_xor_acc_a: assert property (regX && !instrWord[9] |=>
      accOut == $past(accOut ^ memRdata)) else $error("register xor to acc wrong");
   bank_write_a: assert property (regX && instrWord[9:8] == 2'b11 |=>
      memReq.wr && memReq.addr == $past({bankSelect, instrWord[7:0]})
      && memReq.wdata == $past(accOut ^ memRdata)) else $error("banked write wrong");
   stack_ret_a: assert property (retT |=> flow.doReturn && busy ##1 !busy)
      else $error("stack return wrong");
   push_lit_a: assert property (extT && hi == xtsd_pkg::OP_PUSH_LIT |=>
      memReq.wr && memReq.wdata == $past(instrWord[7:0])
      && ptrOut[2] == $past(ptrOut[2]) - 12'h001) else $error("push wrong");
   ext_off_a: assert property (take && !extConfig && !extQ && hi == xtsd_pkg::OP_PTR_ADD |=>
      ptrOut[1] == $past(ptrOut[1])) else $error("extension ran while off");
   // main scenarios reached
   cover property (skipT && memRdata == 8'h00);
   cover property (retT);
   cover property (regX && instrWord[9:8] == 2'b11);
endmodule : xtsd_core_props
bind xtsd_core xtsd_core_props i_props (.ref_clk(ref_clk), .resetn(resetn),
   .instrWord(instrWord), .instrValid(instrValid), .extConfig(extConfig),
   .bankSelect(bankSelect), .memRdata(memRdata), .memReq(memReq), .flow(flow), .accOut(accOut),
   .negFlag(negFlag), .zeroFlag(zeroFlag), .ptrOut(ptrOut), .busy(busy));

// ---- sim/testbench.sv ----
// testbench: directed scenarios for the decode block
`timescale 1ns/1ps
module testbench;
   // stimulus
   logic ref_clk = 1'b0;
   logic resetn = 1'b0;
   logic [15:0] instrWord = 16'h0000;
   logic instrValid = 1'b0;
   logic extConfig = 1'b1;
   logic [3:0] bankSelect = 4'h3;
   logic [7:0] memRdata = 8'h00;
   // observed outputs
   xtsd_pkg::xtsd_mem_t memReq;
   xtsd_pkg::xtsd_flow_t flow;
   logic [7:0] accOut;
   logic negFlag, zeroFlag, busy;
   logic [11:0] ptrOut [3];
   int fails = 0;
   int checks_done = 0;
   // 100 ns clock
   initial begin
      forever #50 ref_clk = ~ref_clk;
   end
   xtsd_core i_dut (.ref_clk(ref_clk), .resetn(resetn), .instrWord(instrWord),
      .instrValid(instrValid), .extConfig(extConfig), .bankSelect(bankSelect),
      .memRdata(memRdata), .memReq(memReq), .flow(flow), .accOut(accOut), .negFlag(negFlag),
      .zeroFlag(zeroFlag), .ptrOut(ptrOut), .busy(busy));
   // compare seen against expected
   task automatic chk(input logic [39:0] got, input logic [39:0] exp);
      checks_done++;
      if (got !== exp) begin
         fails++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   // one word taken on one edge, then settle
   task automatic exec(input logic [15:0] w, input logic [7:0] rd);
      @(posedge ref_clk);
      instrWord <= w;
      memRdata <= rd;
      instrValid <= 1'b1;
      @(posedge ref_clk);
      instrValid <= 1'b0;
      #1;
   endtask : exec
   // pointer adjust and stack return
   task automatic t_ptr;
      exec(16'he87f, 8'h00);
      exec(16'he941, 8'h00);
      chk(ptrOut[1], 12'h03e);
      exec(16'he8e3, 8'h00);
      chk({flow.doReturn, busy, ptrOut[2]}, {2'b11, 12'h023});
      exec(16'he9c1, 8'h00);
      chk({flow.doReturn, ptrOut[2]}, {1'b1, 12'h022});
   endtask : t_ptr
   // push stores then decrements
   task automatic t_push;
      exec(16'hea5a, 8'h00);
      chk({memReq.wr, memReq.addr, memReq.wdata, ptrOut[2]}, {13'h1022, 8'h5a, 12'h021});
   endtask : t_push
   // both exclusive-or forms and address forming
   task automatic t_xor;
      exec(16'h0ab5, 8'h00);
      chk({accOut, negFlag, zeroFlag}, {8'hb5, 2'b10});
      exec(16'h0ab5, 8'h00);
      chk({accOut, negFlag, zeroFlag}, {8'h00, 2'b01});
      exec(16'h1880, 8'haf);
      chk({accOut, memReq.addr}, {8'haf, 12'hf80});
      exec(16'h1b20, 8'h0f);
      chk({memReq.wr, memReq.addr, memReq.wdata, accOut}, {13'h1320, 8'ha0, 8'haf});
      exec(16'h1a5f, 8'h00);
      chk(memReq.addr, 12'h080);
   endtask : t_xor
   // skip over a two-word word, then no skip
   task automatic t_skip;
      exec(16'h0a0f, 8'h00);
      @(posedge ref_clk);
      instrWord <= 16'h6610;
      instrValid <= 1'b1;
      @(posedge ref_clk);
      instrWord <= 16'hc123;
      #1;
      chk({flow.flushNext, busy}, 2'b11);
      @(posedge ref_clk);
      instrValid <= 1'b0;
      #1;
      chk({busy, negFlag, zeroFlag}, 3'b110);
      @(posedge ref_clk);
      #1;
      chk(busy, 1'b0);
      exec(16'h6710, 8'h01);
      chk({flow.flushNext, busy}, 2'b00);
   endtask : t_skip
   // call through accumulator, then extension switched off
   task automatic t_ext;
      exec(16'heb85, 8'h00);
      chk(busy, 1'b1);
      exec(16'hf123, 8'h00);
      chk({flow.moveGo, flow.moveAbs, flow.moveSrcOff, flow.moveDest, busy},
          {2'b10, 8'h05, 12'h123, 1'b0});
      exec(16'h0014, 8'h00);
      chk({flow.doCallAcc, busy}, 2'b11);
      @(posedge ref_clk);
      extConfig <= 1'b0;
      repeat (2) @(posedge ref_clk);
      exec(16'h0014, 8'h00);
      chk(flow.doCallAcc, 1'b0);
      exec(16'h1a10, 8'h00);
      chk(memReq.addr, 12'h010);
   endtask : t_ext
   // verdict and end of run
   task automatic conclude;
      if (fails == 0 && checks_done > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : conclude
   // main sequence
   initial begin
      repeat (2) @(posedge ref_clk);
      resetn <= 1'b1;
      #1;
      chk({accOut, negFlag, zeroFlag, busy, ptrOut[2]}, 23'h0);
      t_ptr();
      t_push();
      t_xor();
      t_skip();
      t_ext();
      conclude();
   end
endmodule : testbench
